// File: src/asfb_pkg.sv
package asfb_pkg;
    // register byte offsets (word aligned)
    localparam logic [4:0] OFS_MODE = 5'h00;
    localparam logic [4:0] OFS_STAT = 5'h04;
    localparam logic [4:0] OFS_DIV = 5'h08;
    localparam logic [4:0] OFS_SRC = 5'h0c;
    localparam logic [4:0] OFS_TXB = 5'h10;
    localparam logic [4:0] OFS_RXB = 5'h14;
    localparam logic [4:0] OFS_TXST = 5'h18;
    // async_mode_reg fields
    localparam int MODE_POWER = 7;
    localparam int MODE_TXE = 6;
    localparam int MODE_RXE = 5;
    localparam int MODE_PAR_HI = 4;
    localparam int MODE_PAR_LO = 3;
    localparam int MODE_CL = 2;
    localparam int MODE_SL = 1;
    localparam logic [7:0] MODE_MASK = 8'hfe;
    localparam logic [7:0] MODE_RST = 8'h00;
    // receive_error_status_reg fields
    localparam int STAT_PERR = 2;
    localparam int STAT_FERR = 1;
    localparam int STAT_OVR = 0;
    // baud_source_select_reg fields: [2:0] exponent n, [3] external pin
    localparam int SRC_EXT = 3;
    localparam logic [3:0] SRC_RST = 4'h0;
    // transfer status fields
    localparam int TXST_RXF = 2;
    localparam int TXST_TXBF = 1;
    localparam int TXST_TXSF = 0;
    // baud_divisor_reg
    localparam logic [7:0] DIV_RST = 8'hff;
    localparam logic [7:0] K_MIN = 8'h08;
    // parity select codes {parity_select_hi, parity_select_lo}
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;
    // bus
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {B_IDLE, B_WR, B_RDW, B_RDD} asfb_bus_t;
    typedef enum logic {TX_IDLE, TX_SHIFT} asfb_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} asfb_rx_t;
endpackage : asfb_pkg

// File: src/asfb_prescale.sv
module asfb_prescale
    import asfb_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic src_tick,
    input wire logic [2:0] exp_n,
    output logic div_tick
);
    typedef struct packed {
        logic [6:0] pre;
        logic tick;
    } asfb_pre_t;

    asfb_pre_t st;
    asfb_pre_t nx;
    logic [6:0] mask;

    assign mask = 7'(({7'h00, 1'b1} << exp_n) - 8'h01);

    always_comb begin
        nx = st;
        nx.tick = 1'b0;
        if (!run) begin
            nx.pre = 7'h00;
        end else if (src_tick) begin
            // one tick per 2^n source clocks
            nx.tick = ((st.pre & mask) == mask);
            nx.pre = st.pre + 7'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '{7'h00, 1'b0};
        end else begin
            st <= nx;
        end
    end

    assign div_tick = st.tick;
endmodule : asfb_prescale

// File: src/asfb_serial_port.sv
// Register access over AHB-Lite and the address map are this design's own decisions.
module asfb_serial_port
    import asfb_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic serial_tx_line,
    input wire logic serial_rx_line,
    input wire logic external_baud_clock_pin
);
    typedef struct packed {
        asfb_bus_t bus;
        logic [4:0] addr;
        logic wr_ok;
        logic [31:0] rdata;
        logic [7:0] mode;
        logic [7:0] kdiv;
        logic [3:0] src;
        logic [2:0] err;
        logic [7:0] txbuf;
        logic txbf;
        logic rxf;
        logic [7:0] rxbuf;
        asfb_tx_t tx_st;
        logic [11:0] tx_sh;
        logic [3:0] tx_left;
        logic [8:0] tx_cnt;
        logic tx_line;
        asfb_rx_t rx_st;
        logic [9:0] rx_sh;
        logic [3:0] rx_left;
        logic [8:0] rx_cnt;
        logic rx_prev;
    } asfb_core_t;

    asfb_core_t st;
    asfb_core_t nx;

    logic rx_lvl;
    logic ext_rise;
    logic div_tick;
    logic src_tick;
    logic power;
    logic acc;
    logic [8:0] bit_cnt;
    logic [8:0] half_cnt;
    logic [3:0] rx_bits;
    logic [9:0] rx_word;
    logic [9:0] rx_v;
    logic [7:0] rx_data;
    logic rx_pbit;
    logic rx_stop;
    logic rx_done;
    logic rx_perr;
    logic [7:0] ld_data;
    logic ld_par;
    logic tx_load;
    logic tx_adv;
    logic [1:0] par_sel;
    logic cl8;

    function automatic logic asfb_tx_par(input logic [7:0] d,
                                         input logic [1:0] p);
        logic ones;
        ones = ^d;
        case (p)
            PAR_EVEN: asfb_tx_par = ones;
            PAR_ODD: asfb_tx_par = ~ones;
            default: asfb_tx_par = 1'b0;
        endcase
    endfunction : asfb_tx_par

    // whole frame, start bit in bit 0; the tail stays high as stop bits
    function automatic logic [11:0] asfb_frame(input logic [7:0] d,
                                               input logic [7:0] m);
        logic [11:0] f;
        f = 12'hfff;
        f[0] = 1'b0;
        f[8:1] = m[MODE_CL] ? d : {1'b1, d[6:0]};
        if (m[MODE_PAR_HI] | m[MODE_PAR_LO]) begin
            if (m[MODE_CL]) begin
                f[9] = asfb_tx_par(d, m[MODE_PAR_HI:MODE_PAR_LO]);
            end else begin
                f[8] = asfb_tx_par({1'b0, d[6:0]},
                                   m[MODE_PAR_HI:MODE_PAR_LO]);
            end
        end
        asfb_frame = f; // no parity slot when none
    endfunction : asfb_frame

    asfb_sync3 #(
        .RESET_VAL(1'b1)
    ) u_rx_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(serial_rx_line),
        .level(rx_lvl),
        .rise()
    );

    asfb_sync3 #(
        .RESET_VAL(1'b0)
    ) u_ext_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(external_baud_clock_pin),
        .level(),
        .rise(ext_rise)
    );

    assign src_tick = st.src[SRC_EXT] ? ext_rise : 1'b1;

    asfb_prescale u_pre (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(power),
        .src_tick(src_tick),
        .exp_n(st.src[2:0]),
        .div_tick(div_tick)
    );

    assign power = st.mode[MODE_POWER];
    assign par_sel = st.mode[MODE_PAR_HI:MODE_PAR_LO];
    assign cl8 = st.mode[MODE_CL];
    // one bit is 2k divider clocks, half a bit is k
    assign bit_cnt = {st.kdiv - 8'h01, 1'b1};
    assign half_cnt = {1'b0, st.kdiv - 8'h01};
    assign acc = hsel & htrans[1] & hready;
    // bits after the start bit up to and including the first stop bit
    assign rx_bits = (cl8 ? 4'h8 : 4'h7) + {3'h0, par_sel != PAR_NONE}
                     + 4'h1;
    assign rx_word = {rx_lvl, st.rx_sh[9:1]};
    assign rx_v = rx_word >> (4'ha - rx_bits);
    assign rx_data = cl8 ? rx_v[7:0] : {1'b0, rx_v[6:0]};
    assign rx_pbit = cl8 ? rx_v[8] : rx_v[7];
    assign rx_stop = rx_v[rx_bits - 4'h1];
    assign rx_done = (st.rx_st == RX_DATA) && div_tick
                     && (st.rx_cnt == 9'h000) && (st.rx_left == 4'h0);
    always_comb begin
        unique case (par_sel)
            PAR_EVEN: rx_perr = ^{rx_data, rx_pbit};
            PAR_ODD: rx_perr = ~^{rx_data, rx_pbit};
            PAR_ZERO, PAR_NONE: rx_perr = 1'b0;
        endcase
    end
    assign tx_load = (st.tx_st == TX_IDLE) && st.txbf && power
                     && st.mode[MODE_TXE];
    assign tx_adv = (st.tx_st == TX_SHIFT) && div_tick
                    && (st.tx_cnt == 9'h000) && (st.tx_left != 4'h0);
    assign ld_data = cl8 ? st.txbuf : {1'b0, st.txbuf[6:0]};
    assign ld_par = asfb_tx_par(ld_data, par_sel);

    always_comb begin
        nx = st;
        // register bus: reads take one wait state so hrdata is a flop
        unique case (st.bus)
            B_RDW: begin
                nx.bus = B_RDD;
                unique case (st.addr)
                    OFS_MODE: nx.rdata = {24'h0, st.mode};
                    OFS_STAT: nx.rdata = {29'h0, st.err};
                    OFS_DIV: nx.rdata = {24'h0, st.kdiv};
                    OFS_SRC: nx.rdata = {28'h0, st.src};
                    OFS_TXB: nx.rdata = {24'h0, st.txbuf};
                    OFS_RXB: nx.rdata = {24'h0, st.rxbuf};
                    OFS_TXST: nx.rdata = {29'h0, st.rxf, st.txbf,
                                          st.tx_st == TX_SHIFT};
                    default: nx.rdata = 32'h0;
                endcase
                if (st.addr == OFS_RXB) begin
                    nx.rxf = 1'b0;
                end
            end
            B_IDLE, B_WR, B_RDD: begin
                if (acc) begin
                    nx.bus = hwrite ? B_WR : B_RDW;
                    nx.addr = haddr[4:0];
                    nx.wr_ok = (hsize == HSIZE_WORD) && (haddr[31:5] == 27'h0);
                end else begin
                    nx.bus = B_IDLE;
                end
            end
        endcase
        if (acc && !hwrite && haddr[31:5] != 27'h0) begin
            nx.addr = 5'h1f;
        end

        if (st.bus == B_WR && st.wr_ok) begin
            unique case (st.addr)
                OFS_MODE: nx.mode = hwdata[7:0] & MODE_MASK;
                OFS_STAT: nx.err = st.err & ~hwdata[2:0];
                OFS_DIV: begin
                    // out-of-range divisors are dropped, old k stays
                    if (hwdata[7:0] >= K_MIN) begin
                        nx.kdiv = hwdata[7:0];
                    end
                end
                OFS_SRC: nx.src = hwdata[3:0];
                OFS_TXB: begin
                    // a full buffer refuses the write
                    if (power && st.mode[MODE_TXE] && !st.txbf) begin
                        nx.txbuf = hwdata[7:0];
                        nx.txbf = 1'b1;
                    end
                end
                default: nx.mode = st.mode;
            endcase
        end

        // transmitter
        unique case (st.tx_st)
            TX_IDLE: begin
                nx.tx_line = 1'b1;
                if (tx_load) begin
                    nx.tx_sh = asfb_frame(st.txbuf, st.mode);
                    nx.tx_line = 1'b0;
                    nx.tx_left = 4'h1 + (cl8 ? 4'h8 : 4'h7)
                                 + {3'h0, par_sel != PAR_NONE}
                                 + (st.mode[MODE_SL] ? 4'h2 : 4'h1)
                                 - 4'h1;
                    nx.tx_cnt = bit_cnt;
                    nx.txbf = 1'b0;
                    nx.tx_st = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (div_tick) begin
                    if (st.tx_cnt != 9'h000) begin
                        nx.tx_cnt = st.tx_cnt - 9'h001;
                    end else if (st.tx_left == 4'h0) begin
                        nx.tx_st = TX_IDLE;
                        nx.tx_line = 1'b1;
                    end else begin
                        nx.tx_sh = {1'b1, st.tx_sh[11:1]};
                        nx.tx_line = st.tx_sh[1];
                        nx.tx_left = st.tx_left - 4'h1;
                        nx.tx_cnt = bit_cnt;
                    end
                end
            end
        endcase
        if (!power || !st.mode[MODE_TXE]) begin
            nx.tx_st = TX_IDLE;
            nx.tx_line = power; // line low while power is off, high while only the transmitter is disabled
        end

        // receiver
        nx.rx_prev = rx_lvl;
        unique case (st.rx_st)
            RX_IDLE: begin
                if (st.rx_prev && !rx_lvl) begin
                    nx.rx_st = RX_START;
                    nx.rx_cnt = half_cnt;
                end
            end
            RX_START: begin
                if (div_tick) begin
                    if (st.rx_cnt != 9'h000) begin
                        nx.rx_cnt = st.rx_cnt - 9'h001;
                    end else if (!rx_lvl) begin
                        nx.rx_st = RX_DATA;
                        nx.rx_cnt = bit_cnt;
                        nx.rx_left = rx_bits - 4'h1;
                    end else begin
                        // glitch, not a start bit
                        nx.rx_st = RX_IDLE;
                    end
                end
            end
            RX_DATA: begin
                if (div_tick) begin
                    if (st.rx_cnt != 9'h000) begin
                        nx.rx_cnt = st.rx_cnt - 9'h001;
                    end else begin
                        nx.rx_sh = rx_word;
                        nx.rx_cnt = bit_cnt;
                        nx.rx_left = st.rx_left - 4'h1;
                    end
                end
                // mid-bit sample of the stop bit: k-2 >= 6 divider clocks
                // spare either side, more than the two needed
                if (rx_done) begin
                    nx.rx_st = RX_IDLE;
                    nx.rxbuf = rx_data;
                    nx.rxf = 1'b1;
                    // build on nx so a clear in this cycle is kept, set wins
                    nx.err[STAT_PERR] = nx.err[STAT_PERR] | rx_perr;
                    nx.err[STAT_FERR] = nx.err[STAT_FERR] | ~rx_stop;
                    nx.err[STAT_OVR] = nx.err[STAT_OVR] | st.rxf;
                end
            end
            default: nx.rx_st = RX_IDLE;
        endcase
        if (!power || !st.mode[MODE_RXE]) begin
            nx.rx_st = RX_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '{B_IDLE, 5'h00, 1'b0, 32'h0, MODE_RST, DIV_RST, SRC_RST,
                    3'h0, 8'h00, 1'b0, 1'b0, 8'h00, TX_IDLE, 12'hfff, 4'h0,
                    9'h000, 1'b0, RX_IDLE, 10'h000, 4'h0, 9'h000, 1'b1};
        end else begin
            st <= nx;
        end
    end

    assign hreadyout = (st.bus != B_RDW);
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign serial_tx_line = st.tx_line;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic tx_idle_q;
    assign tx_idle_q = power && (st.tx_st == TX_IDLE);

    AST_TX_IDLE_HIGH: assert property (
        tx_idle_q && $past(tx_idle_q) && !$past(tx_load)
        |-> serial_tx_line)
        else $error("transmit line not high while idle");
    AST_POWER_OFF_LOW: assert property (
        !power |=> !serial_tx_line)
        else $error("transmit line not low with clock stopped");
    AST_START_LOW: assert property (
        tx_load |=> !serial_tx_line && st.tx_st == TX_SHIFT && !st.txbf)
        else $error("frame did not open with a low start bit");
    AST_BIT_RELOAD: assert property (
        tx_adv |=> st.tx_cnt == {$past(st.kdiv) - 8'h01, 1'b1})
        else $error("bit period is not 2k divider clocks");
    AST_K_RANGE: assert property (
        st.kdiv >= K_MIN)
        else $error("divisor below minimum");
    AST_PAR_EVEN: assert property (
        tx_load && par_sel == PAR_EVEN |-> ^{ld_data, ld_par} == 1'b0)
        else $error("even parity bit wrong");
    AST_PAR_ODD: assert property (
        tx_load && par_sel == PAR_ODD |-> ^{ld_data, ld_par} == 1'b1)
        else $error("odd parity bit wrong");
    AST_PAR_ZERO: assert property (
        tx_load && par_sel == PAR_ZERO |=> st.tx_sh[cl8 ? 9 : 8] == 1'b0)
        else $error("zero parity bit not zero");
    AST_RX7_TOP: assert property (
        rx_done && !cl8 |=> st.rxbuf[7] == 1'b0 ##1 st.rxbuf[7] == 1'b0)
        else $error("seven-bit receive left bit 7 set");
    AST_NO_PERR: assert property (
        rx_done && !par_sel[1] && !st.err[STAT_PERR]
        |=> !st.err[STAT_PERR])
        else $error("parity error raised without checking");
    AST_FERR: assert property (
        rx_done && !rx_stop |=> st.err[STAT_FERR] && st.rx_st == RX_IDLE)
        else $error("low stop bit not flagged");

    COV_TX_FRAME: cover property (tx_load ##[1:1000] st.tx_st == TX_IDLE);
    COV_RX_DONE: cover property (rx_done);
    COV_RX_PERR: cover property (rx_done && rx_perr);
    COV_RX_FERR: cover property (rx_done && !rx_stop);
endmodule : asfb_serial_port

// File: src/asfb_sync3.sv
module asfb_sync3
    import asfb_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin,
    output logic level,
    output logic rise
);
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic lvl;
        logic rise;
    } asfb_sync_t;

    asfb_sync_t st;
    asfb_sync_t nx;

    always_comb begin
        nx = st;
        nx.ff1 = pin;
        nx.ff2 = st.ff1;
        nx.ff3 = st.ff2;
        // a change only counts once the last two stages agree
        if (st.ff2 == st.ff3) begin
            nx.lvl = st.ff3;
        end
        nx.rise = nx.lvl & ~st.lvl;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL, 1'b0};
        end else begin
            st <= nx;
        end
    end

    assign level = st.lvl;
    assign rise = st.rise;
endmodule : asfb_sync3

// File: verification/asfb_remote.sv
module asfb_remote (
    input wire logic hclk,
    input wire logic serial_tx_line,
    output logic serial_rx_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle high when no frame is sent, like a released line with pull-up
    initial serial_rx_line = 1'b1;
    task automatic send(input logic [11:0] f, input int len, input int cyc);
        for (int i = 0; i < len; i++) begin
            serial_rx_line <= f[i];
            repeat (cyc) @(posedge hclk);
        end
        serial_rx_line <= 1'b1;
    endtask : send
    // samples mid-bit; unsent positions read as ones
    task automatic grab(input int len, input int cyc, output logic [11:0] f);
        f = 12'hfff;
        @(negedge serial_tx_line);
        repeat (cyc / 2) @(posedge hclk);
        for (int i = 0; i < len; i++) begin
            f[i] = serial_tx_line;
            repeat (cyc) @(posedge hclk);
        end
    endtask : grab
endmodule : asfb_remote

// File: verification/tb_async_serial_frame_baud.sv
module tb_async_serial_frame_baud;
    import asfb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic [31:0] hrdata;
    logic tx;
    logic rx;
    logic ext_pin = 1'b0;
    logic ext_ph = 1'b0;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] v;
    logic [11:0] f;
    logic [7:0] d;
    int len;

    assign hready = hreadyout;
    always #25 hclk = ~hclk;
    // external source runs at a quarter of the bus clock; any faster and
    // the last two sync stages never agree, so no edge would count
    always @(posedge hclk) begin
        ext_ph <= ~ext_ph;
        if (ext_ph) begin
            ext_pin <= ~ext_pin;
        end
    end

    asfb_serial_port i_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(),
        .hrdata(hrdata),
        .serial_tx_line(tx),
        .serial_rx_line(rx),
        .external_baud_clock_pin(ext_pin)
    );
    asfb_remote i_far (
        .hclk(hclk),
        .serial_tx_line(tx),
        .serial_rx_line(rx)
    );

    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic [4:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] q);
        haddr <= {27'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [31:0] wd);
        logic [31:0] q;
        bus(a, 1'b1, wd, q);
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bus(a, 1'b0, 32'h0, q);
    endtask : rd
    // m = {parity code, 8-bit select, two-stop select}
    function automatic logic [11:0] frame(input logic [7:0] dv,
            input logic [3:0] m, input logic flip, output int n);
        logic [11:0] fr;
        logic [7:0] dd;
        int p;
        dd = m[1] ? dv : {1'b0, dv[6:0]};
        fr = 12'hfff;
        fr[0] = 1'b0;
        for (int i = 0; i < 7 + m[1]; i++) fr[1 + i] = dd[i];
        p = 8 + m[1];
        if (m[3:2] != PAR_NONE) begin
            fr[p] = (m[3:2] == PAR_EVEN ? ^dd :
                     m[3:2] == PAR_ODD ? ~^dd : 1'b0) ^ flip;
            p++;
        end
        n = p + 1 + m[0];
        return fr;
    endfunction : frame
    task automatic tx_chk(input logic [7:0] dv, input logic [3:0] m,
                          input int cyc);
        logic [11:0] got;
        logic [11:0] e;
        int n;
        e = frame(dv, m, 1'b0, n);
        fork
            i_far.grab(n, cyc, got);
            wr(OFS_TXB, {24'h0, dv});
        join
        // grab ends half a bit after the last stop bit does
        repeat (cyc) @(posedge hclk);
        chk("tx frame", {20'h0, got}, {20'h0, e});
    endtask : tx_chk
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    initial begin
        repeat (40000) @(posedge hclk);
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1; // no shared synchronous unit is fitted here
        @(posedge hclk);
        chk("stopped line", {31'h0, tx}, 32'h0);
        rd(OFS_MODE, v);
        chk("mode reset", v, {24'h0, MODE_RST});
        rd(OFS_DIV, v);
        chk("div reset", v, {24'h0, DIV_RST});
        wr(OFS_DIV, 32'h7);
        rd(OFS_DIV, v);
        chk("div refused", v, {24'h0, DIV_RST});
        rd(5'h1c, v);
        chk("unmapped", v, 32'h0);
        wr(OFS_DIV, {24'h0, K_MIN});
        wr(OFS_MODE, 32'h80);
        repeat (2) @(posedge hclk);
        chk("idle line", {31'h0, tx}, 32'h1);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            d = 8'hb6 ^ {i[3:0], i[3:0]};
            wr(OFS_MODE, {24'h0, 3'b111, i[3:0], 1'b0});
            rd(OFS_MODE, v);
            chk("mode", v, {24'h0, 3'b111, i[3:0], 1'b0});
            tx_chk(d, i[3:0], 16);
            rd(OFS_TXST, v);
            chk("tx done", v, 32'h0);
            f = frame(d, i[3:0], i[1] ^ i[0], len);
            i_far.send(f, len, 16);
            repeat (20) @(posedge hclk);
            rd(OFS_RXB, v);
            chk("rx data", v, {24'h0, i[1] ? d : d & 8'h7f});
            rd(OFS_STAT, v);
            chk("rx status", v, {29'h0, (i[1] ^ i[0]) & i[3], 2'h0});
            wr(OFS_STAT, 32'h7);
        end
        $display("test modes done");
        wr(OFS_MODE, 32'he4);
        f = frame(8'h5a, 4'h2, 1'b0, len);
        f[9] = 1'b0;
        i_far.send(f, len, 16);
        repeat (20) @(posedge hclk);
        rd(OFS_STAT, v);
        chk("frame err", v, 32'h2);
        wr(OFS_STAT, 32'h7);
        rd(OFS_RXB, v);
        $display("test errors done");
        wr(OFS_DIV, 32'h20);
        for (int c = 62; c <= 66; c += 4) begin
            f = frame(8'hc3, 4'h2, 1'b0, len);
            i_far.send(f, len, c);
            repeat (40) @(posedge hclk);
            rd(OFS_RXB, v);
            chk("rx tolerance", v, 32'hc3);
        end
        wr(OFS_DIV, {24'h0, K_MIN});
        wr(OFS_SRC, 32'h1);
        tx_chk(8'h81, 4'h2, 32);
        wr(OFS_SRC, 32'h8);
        tx_chk(8'h3e, 4'h2, 64);
        $display("test rates done");
        end_sim();
    end
endmodule : tb_async_serial_frame_baud
